// [pkg/memmap_pkg.sv]
// package for the on-chip memory map decoder
// assumes a 16-bit cpu address space and byte-wide data
package memmap_pkg;

	// ----------------------------------------------------------------
	// address map
	// ----------------------------------------------------------------
	localparam logic [15:0] map_reg_offset   = 16'h103d;
	localparam logic [7:0]  map_reg_reset    = 8'h01;
	localparam logic [5:0]  map_reg_index    = 6'h3d;
	localparam logic [5:0]  ctrl_opt_index   = 6'h39;
	localparam logic [5:0]  nvm_prog_index   = 6'h3b;
	localparam logic [5:0]  nvm_cfg_index    = 6'h3f;
	localparam logic [15:0] rom_base         = 16'he000;
	localparam logic [15:0] boot_base        = 16'hbf40;
	localparam logic [15:0] vec_base         = 16'hbfc0;
	localparam logic [15:0] nvm_base         = 16'hb600;
	localparam logic [15:0] nvm_last         = 16'hb7ff;
	localparam int          ram_bytes        = 256;
	localparam int          ctrl_bytes       = 64;
	localparam int          nvm_bytes        = 512;
	localparam int          boot_bytes       = 192;
	localparam logic [7:0]  nvm_erased       = 8'hff;
	localparam logic [7:0]  undriven_value   = 8'hff;
	localparam int          write_window     = 64;
	localparam logic [7:0]  ctrl_cfg_reset   = 8'h0f;
	localparam logic [7:0]  prog_write_mask  = 8'hdf;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int sram_page_field_msb = 7;
	localparam int sram_page_field_lsb = 4;
	localparam int ctrl_block_page_msb = 3;
	localparam int ctrl_block_page_lsb = 0;
	localparam int pump_clock_select   = 6;
	localparam int mask_rom_enable     = 1;
	localparam int nvm_array_enable    = 0;
	localparam int prog_erase_bit      = 2;
	localparam int prog_latch_bit      = 1;
	localparam int prog_pump_bit       = 0;
	localparam int prog_byte_bit       = 4;
	localparam int prog_row_bit        = 3;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		mode_single    = 2'b00,
		mode_expanded  = 2'b01,
		mode_bootstrap = 2'b10,
		mode_test      = 2'b11
	} op_mode_e;

	typedef enum logic [2:0]
	{
		sel_none = 3'b000,
		sel_ctrl = 3'b001,
		sel_ram  = 3'b010,
		sel_rom  = 3'b011,
		sel_boot = 3'b100,
		sel_nvm  = 3'b101
	} target_e;

	typedef struct packed
	{
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} cpu_req_s;

	typedef struct packed
	{
		logic        rw_n_read;
		logic        address_strobe;
		logic [15:0] addr;
		logic [7:0]  data_out;
		logic        data_oe;
		logic        external_region;
	} ext_bus_s;

endpackage : memmap_pkg

// [hdl/memmap_target.sv]
// target decode with internal priority ordering
// assumes map register and enables are already resolved
`timescale 1ns/1ps

module memmap_target
(
	input  wire logic [15:0]        addr,
	input  wire logic [7:0]         map_value,
	input  wire logic               rom_on,
	input  wire logic               boot_on,
	input  wire logic               nvm_on,
	output memmap_pkg::target_e     target
);

	// ----------------------------------------------------------------
	// priority decode
	// ----------------------------------------------------------------
	logic hit_ctrl;
	logic hit_ram;
	logic hit_rom;
	logic hit_boot;
	logic hit_nvm;

	always_comb
	begin
		hit_ctrl = addr[15:12] == map_value[memmap_pkg::ctrl_block_page_msb:
			memmap_pkg::ctrl_block_page_lsb] && addr[11:6] == 6'h00;
		hit_ram  = addr[15:12] == map_value[memmap_pkg::sram_page_field_msb:
			memmap_pkg::sram_page_field_lsb] && addr[11:8] == 4'h0;
		hit_rom  = rom_on && addr >= memmap_pkg::rom_base;
		hit_boot = boot_on && addr >= memmap_pkg::boot_base
			&& addr < 16'(memmap_pkg::boot_base + memmap_pkg::boot_bytes);
		hit_nvm  = nvm_on && addr >= memmap_pkg::nvm_base
			&& addr <= memmap_pkg::nvm_last;
		if (hit_ctrl)
			target = memmap_pkg::sel_ctrl;
		else if (hit_ram)
			target = memmap_pkg::sel_ram;
		else if (hit_rom)
			target = memmap_pkg::sel_rom;
		else if (hit_boot)
			target = memmap_pkg::sel_boot;
		else if (hit_nvm)
			target = memmap_pkg::sel_nvm;
		else
			target = memmap_pkg::sel_none;
	end

endmodule : memmap_target

// [hdl/memmap_decoder.sv]
// on-chip memory map decoder with ram, eeprom array and mapping register
// assumes cpu strobes synchronous to clock; rom and boot contents outside
//
// What this block does
// - internal resources win over an overlapping external device
// - reads of internal addresses ignore external data inputs
// - writes to internal addresses also drive external data pins
// - strobes, address and write data appear externally on every access
// - bootstrap mode enables boot program bf40-bfff with vectors inside
// - test mode uses expanded map, vectors fetched externally
// - control block relocatable to any 4k page by mapping register
// - mapping register writable once, within 64 cycles after reset
// - mapping register resets to 01: ram at 0000, block at 1000
// - mapping nibbles compared with address bits 15 to 12
// - ram wins over rom at e000 or f000
// - control block wins over overlapping ram or rom
// - unused control block locations read the undriven bus value
// - 8k rom at e000-ffff, off when rom enable bit clear outside single-chip mode
// - single-chip mode keeps rom on regardless of enable bit
// - boot rom enabled only after reset in bootstrap mode
// - ram defaults to 0000-00ff and keeps contents in low power
// - eeprom at b600-b7ff, disabled when array enable bit zero
// - erased byte reads ff; programming ands old with new data
// - below 1 mhz software selects rc pump clock and waits 10 ms
// - eeprom disconnected from read bus while programming
`timescale 1ns/1ps

module memmap_decoder
#(
	parameter int addr_width = 16,
	parameter int data_width = 8
)
(
	input  wire logic                       clock,
	input  wire logic                       rst,
	input  wire logic [1:0]                 mode_pins,
	input  wire memmap_pkg::cpu_req_s       cpu_req,
	output logic [data_width-1:0]           cpu_rdata,
	input  wire logic [data_width-1:0]      ext_data_in,
	output memmap_pkg::ext_bus_s            ext_bus,
	input  wire logic [data_width-1:0]      rom_data,
	input  wire logic [data_width-1:0]      boot_data,
	input  wire logic                       low_power,
	output logic                            pump_clock_sel,
	output logic                            nvm_busy
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	memmap_pkg::op_mode_e   mode_r;
	memmap_pkg::op_mode_e   mode_nxt;
	memmap_pkg::op_mode_e   mode_eff;
	logic                   strap_done_r;
	logic [7:0]             map_r;
	logic [7:0]             map_nxt;
	logic                   win_open_r;
	logic                   win_open_nxt;
	logic [6:0]             win_cnt_r;
	logic [6:0]             win_cnt_nxt;
	logic [7:0]             cfg_r;
	logic [7:0]             cfg_nxt;
	logic [7:0]             prog_r;
	logic [7:0]             prog_nxt;
	logic [7:0]             opt_r;
	logic [7:0]             opt_nxt;
	logic [8:0]             lat_addr_r;
	logic [8:0]             lat_addr_nxt;
	logic [7:0]             lat_data_r;
	logic [7:0]             lat_data_nxt;
	logic                   lat_valid_r;
	logic                   lat_valid_nxt;
	logic [7:0]             ram_r [memmap_pkg::ram_bytes];
	logic [7:0]             nvm_r [memmap_pkg::nvm_bytes];
	logic [7:0]             rdata_nxt;
	memmap_pkg::target_e    target;
	logic                   rom_on;
	logic                   boot_on;
	logic                   nvm_on;
	logic                   pump_rise;
	logic [8:0]             nvm_idx;
	logic [7:0]             ram_idx;
	logic [5:0]             ctrl_idx;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] program_byte(input logic [7:0] old_v,
		input logic [7:0] new_v);
		program_byte = old_v & new_v;
	endfunction : program_byte

	function automatic logic same_row(input logic [8:0] a, input logic [8:0] b);
		same_row = a[8:4] == b[8:4];
	endfunction : same_row

	// ----------------------------------------------------------------
	// enables and decode
	// ----------------------------------------------------------------
	always_comb
	begin
		mode_eff = strap_done_r ? mode_r : memmap_pkg::op_mode_e'(mode_pins);
		rom_on   = cfg_r[memmap_pkg::mask_rom_enable]
			|| mode_eff == memmap_pkg::mode_single;
		boot_on  = mode_eff == memmap_pkg::mode_bootstrap;
		nvm_on   = cfg_r[memmap_pkg::nvm_array_enable];
		nvm_idx  = cpu_req.addr[8:0] - memmap_pkg::nvm_base[8:0];
		ram_idx  = cpu_req.addr[7:0];
		ctrl_idx = cpu_req.addr[5:0];
		pump_rise = cpu_req.wr && target == memmap_pkg::sel_ctrl
			&& ctrl_idx == memmap_pkg::nvm_prog_index
			&& cpu_req.wdata[memmap_pkg::prog_pump_bit]
			&& cpu_req.wdata[memmap_pkg::prog_latch_bit]
			&& prog_r[memmap_pkg::prog_latch_bit];
	end

	memmap_target u_target
	(
		.addr      (cpu_req.addr),
		.map_value (map_r),
		.rom_on    (rom_on),
		.boot_on   (boot_on),
		.nvm_on    (nvm_on),
		.target    (target)
	);

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	always_comb
	begin
		mode_nxt      = mode_r;
		map_nxt       = map_r;
		win_open_nxt  = win_open_r;
		win_cnt_nxt   = win_cnt_r;
		cfg_nxt       = cfg_r;
		prog_nxt      = prog_r;
		opt_nxt       = opt_r;
		lat_addr_nxt  = lat_addr_r;
		lat_data_nxt  = lat_data_r;
		lat_valid_nxt = lat_valid_r;
		if (!strap_done_r)
			mode_nxt = memmap_pkg::op_mode_e'(mode_pins);
		if (win_open_r)
		begin
			win_cnt_nxt = win_cnt_r + 7'h01;
			if (win_cnt_r == 7'(memmap_pkg::write_window - 1))
				win_open_nxt = 1'b0;
		end
		if (cpu_req.wr && target == memmap_pkg::sel_ctrl)
		begin
			unique case (ctrl_idx)
				memmap_pkg::map_reg_index:
				begin
					if (win_open_r)
					begin
						map_nxt      = cpu_req.wdata;
						win_open_nxt = 1'b0;
					end
				end
				memmap_pkg::ctrl_opt_index:
					opt_nxt = cpu_req.wdata;
				memmap_pkg::nvm_cfg_index:
					cfg_nxt = cpu_req.wdata;
				memmap_pkg::nvm_prog_index:
				begin
					prog_nxt = cpu_req.wdata & memmap_pkg::prog_write_mask;
					if (cpu_req.wdata[memmap_pkg::prog_latch_bit]
						&& cpu_req.wdata[memmap_pkg::prog_pump_bit]
						&& !prog_r[memmap_pkg::prog_latch_bit])
					begin
						prog_nxt[memmap_pkg::prog_latch_bit] = 1'b0;
						prog_nxt[memmap_pkg::prog_pump_bit]  = 1'b0;
					end
					if (!cpu_req.wdata[memmap_pkg::prog_latch_bit])
						lat_valid_nxt = 1'b0;
				end
				default:
				begin
				end
			endcase
		end
		if (cpu_req.wr && target == memmap_pkg::sel_nvm
			&& prog_r[memmap_pkg::prog_latch_bit]
			&& !prog_r[memmap_pkg::prog_pump_bit])
		begin
			lat_addr_nxt  = nvm_idx;
			lat_data_nxt  = cpu_req.wdata;
			lat_valid_nxt = 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			mode_r       <= memmap_pkg::mode_single;
			strap_done_r <= 1'b0;
			map_r        <= memmap_pkg::map_reg_reset;
			win_open_r   <= 1'b1;
			win_cnt_r    <= 7'h00;
			cfg_r        <= memmap_pkg::ctrl_cfg_reset;
			prog_r       <= 8'h00;
			opt_r        <= 8'h00;
			lat_addr_r   <= 9'h000;
			lat_data_r   <= 8'h00;
			lat_valid_r  <= 1'b0;
		end
		else
		begin
			mode_r       <= mode_nxt;
			strap_done_r <= 1'b1;
			map_r        <= map_nxt;
			win_open_r   <= win_open_nxt;
			win_cnt_r    <= win_cnt_nxt;
			cfg_r        <= cfg_nxt;
			prog_r       <= prog_nxt;
			opt_r        <= opt_nxt;
			lat_addr_r   <= lat_addr_nxt;
			lat_data_r   <= lat_data_nxt;
			lat_valid_r  <= lat_valid_nxt;
		end
	end

	// ----------------------------------------------------------------
	// storage arrays
	// ----------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (cpu_req.wr && target == memmap_pkg::sel_ram)
			ram_r[ram_idx] <= cpu_req.wdata;
		if (pump_rise && lat_valid_r)
		begin
			for (int i = 0; i < memmap_pkg::nvm_bytes; i++)
			begin
				if (!prog_r[memmap_pkg::prog_erase_bit])
				begin
					if (9'(i) == lat_addr_r)
						nvm_r[i] <= program_byte(nvm_r[i], lat_data_r);
				end
				else if (prog_r[memmap_pkg::prog_byte_bit] ? 9'(i) == lat_addr_r
					: (!prog_r[memmap_pkg::prog_row_bit] || same_row(9'(i), lat_addr_r)))
					nvm_r[i] <= memmap_pkg::nvm_erased;
			end
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_comb
	begin
		rdata_nxt = memmap_pkg::undriven_value;
		unique case (target)
			memmap_pkg::sel_ctrl:
			begin
				unique case (ctrl_idx)
					memmap_pkg::map_reg_index:  rdata_nxt = map_r;
					memmap_pkg::ctrl_opt_index: rdata_nxt = opt_r;
					memmap_pkg::nvm_prog_index: rdata_nxt = prog_r;
					memmap_pkg::nvm_cfg_index:  rdata_nxt = cfg_r;
					default:  rdata_nxt = memmap_pkg::undriven_value;
				endcase
			end
			memmap_pkg::sel_ram:  rdata_nxt = ram_r[ram_idx];
			memmap_pkg::sel_rom:  rdata_nxt = rom_data;
			memmap_pkg::sel_boot: rdata_nxt = boot_data;
			memmap_pkg::sel_nvm:
				if (!prog_r[memmap_pkg::prog_latch_bit])
					rdata_nxt = nvm_r[nvm_idx];
			memmap_pkg::sel_none: rdata_nxt = ext_data_in;
			default:  rdata_nxt = memmap_pkg::undriven_value;
		endcase
	end

	// internal hits never take external data
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			cpu_rdata <= '0;
		else if (cpu_req.rd)
			cpu_rdata <= rdata_nxt;
	end

	// ----------------------------------------------------------------
	// external bus
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			ext_bus <= '0;
		else
		begin
			ext_bus.rw_n_read       <= !cpu_req.wr;
			ext_bus.address_strobe  <= cpu_req.rd || cpu_req.wr;
			ext_bus.addr            <= cpu_req.addr;
			ext_bus.data_out        <= cpu_req.wdata;
			ext_bus.data_oe         <= cpu_req.wr;
			ext_bus.external_region <= target == memmap_pkg::sel_none;
		end
	end

	always_comb
	begin
		pump_clock_sel = opt_r[memmap_pkg::pump_clock_select] || low_power == 1'b0
			&& opt_r[memmap_pkg::pump_clock_select];
		nvm_busy       = prog_r[memmap_pkg::prog_pump_bit];
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	map_reset_a: assert property (@(posedge clock) $fell(rst) |-> map_r == 8'h01)
		else $error("map register not 01 after reset");
	map_locked_a: assert property (@(posedge clock) disable iff (rst)
		!win_open_r |=> $stable(map_r))
		else $error("map register changed after lock");
	ram_wins_a: assert property (@(posedge clock) disable iff (rst)
		cpu_req.addr[15:12] == map_r[7:4] && cpu_req.addr[11:8] == 4'h0
		&& target != memmap_pkg::sel_ctrl |-> target == memmap_pkg::sel_ram)
		else $error("ram lost priority");
	ctrl_wins_a: assert property (@(posedge clock) disable iff (rst)
		cpu_req.addr[15:12] == map_r[3:0] && cpu_req.addr[11:6] == 6'h00
		|-> target == memmap_pkg::sel_ctrl)
		else $error("control block lost priority");
	ext_ignore_a: assert property (@(posedge clock) disable iff (rst)
		cpu_req.rd && target == memmap_pkg::sel_ram
		|=> cpu_rdata == $past(ram_r[ram_idx]))
		else $error("read data wrong");
	ext_write_a: assert property (@(posedge clock) disable iff (rst)
		cpu_req.wr |=> ext_bus.data_oe && ext_bus.data_out == $past(cpu_req.wdata))
		else $error("write data not driven out");
	strobe_out_a: assert property (@(posedge clock) disable iff (rst)
		cpu_req.rd |=> ext_bus.address_strobe && ext_bus.rw_n_read)
		else $error("strobe missing");
	rom_single_a: assert property (@(posedge clock) disable iff (rst)
		mode_eff == memmap_pkg::mode_single && cpu_req.addr[15:13] == 3'h7
		&& cpu_req.addr[15:12] != map_r[7:4] && cpu_req.addr[15:12] != map_r[3:0]
		|-> target == memmap_pkg::sel_rom)
		else $error("rom off in single chip");
	window_close_a: assert property (@(posedge clock) disable iff (rst)
		win_cnt_r == 7'(memmap_pkg::write_window - 1) |=> !win_open_r)
		else $error("window stayed open");

endmodule : memmap_decoder

// [testbench/ext_device.sv]
// external expanded-mode device on the multiplexed data port
// assumes ext_bus registered by the decoder, one clock
`timescale 1ns/1ps

module ext_device
(
	input  wire logic                 clock,
	input  wire logic                 rst,
	input  wire memmap_pkg::ext_bus_s ext_bus,
	output logic [7:0]                ext_data_in
);

	// ----------------------------------------------------------------
	// junk data source
	// ----------------------------------------------------------------
	logic [3:0] cnt_r;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			cnt_r <= 4'h0;
		else
			cnt_r <= cnt_r + 4'h1;
	end

	// pattern changes every cycle, released value inverted on writes
	assign ext_data_in = (ext_bus.address_strobe && !ext_bus.rw_n_read) ?
		{4'h6, ~cnt_r} : {4'h6, cnt_r};

endmodule : ext_device

// [testbench/tb_top.sv]
// self-checking bench for the memory map decoder
// assumes ext_device as far side and the decoder package
`timescale 1ns/1ps

module tb_top;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic                 clock     = 1'b0;
	logic                 rst       = 1'b1;
	logic [1:0]           mode_pins = 2'b01;
	memmap_pkg::cpu_req_s cpu_req   = '0;
	logic [7:0]           cpu_rdata;
	logic [7:0]           ext_data_in;
	memmap_pkg::ext_bus_s ext_bus;
	logic [7:0]           rom_data  = 8'ha0;
	logic [7:0]           boot_data = 8'hb0;
	logic                 low_power = 1'b0;
	logic                 pump_clock_sel;
	logic                 nvm_busy;
	logic                 taken_rd  = 1'b0;
	logic                 taken_rq  = 1'b0;
	logic [15:0]          rq[$];
	logic [27:0]          eq[$];
	logic [15:0]          rq_head;
	logic [15:0]          cb;
	logic [7:0]           d;
	int                   mismatches = 0;
	int                   n_checks   = 0;
	int                   cycles     = 0;

	always #2 clock = ~clock;

	memmap_decoder DUT
	(
		.clock          (clock),
		.rst            (rst),
		.mode_pins      (mode_pins),
		.cpu_req        (cpu_req),
		.cpu_rdata      (cpu_rdata),
		.ext_data_in    (ext_data_in),
		.ext_bus        (ext_bus),
		.rom_data       (rom_data),
		.boot_data      (boot_data),
		.low_power      (low_power),
		.pump_clock_sel (pump_clock_sel),
		.nvm_busy       (nvm_busy)
	);

	ext_device far_side
	(
		.clock       (clock),
		.rst         (rst),
		.ext_bus     (ext_bus),
		.ext_data_in (ext_data_in)
	);

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	task automatic do_reset(input logic [1:0] m);
		rst       <= 1'b1;
		mode_pins <= m;
		cpu_req   <= '0;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
	endtask : do_reset

	task automatic idle(input int n);
		cpu_req <= '0;
		repeat (n) @(posedge clock);
	endtask : idle

	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		cpu_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
		eq.push_back({4'b1010, a, v});
		@(posedge clock);
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
		cpu_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		rq.push_back({m, e & m});
		eq.push_back({3'b110, m != 8'hff, a, 8'h00});
		@(posedge clock);
	endtask : rd

	task automatic prog(input logic [15:0] a, input logic [7:0] v);
		wr(cb + 16'h003b, 8'h02);
		wr(a, v);
		rd(a, memmap_pkg::nvm_erased, 8'hff);
		wr(cb + 16'h003b, 8'h03);
		idle(1);
		check(nvm_busy, 1'b1);
		wr(cb + 16'h003b, 8'h00);
	endtask : prog

	task automatic erase_all;
		wr(cb + 16'h003b, 8'h06);
		wr(16'hb600, 8'h00);
		wr(cb + 16'h003b, 8'h07);
		idle(1);
		check(nvm_busy, 1'b1);
		wr(cb + 16'h003b, 8'h00);
	endtask : erase_all

	// ----------------------------------------------------------------
	// monitor and timeout
	// ----------------------------------------------------------------
	always @(posedge clock)
	begin
		taken_rd <= cpu_req.rd;
		taken_rq <= cpu_req.rd | cpu_req.wr;
		cycles++;
		if (cycles == 4000)
		begin
			mismatches++;
			stop_test();
		end
	end

	always @(negedge clock)
	begin
		if (taken_rq && eq.size() > 0)
			check({ext_bus.address_strobe, ext_bus.rw_n_read, ext_bus.data_oe,
				ext_bus.external_region, ext_bus.addr,
				ext_bus.data_oe ? ext_bus.data_out : 8'h00}, eq.pop_front());
		if (taken_rd && rq.size() > 0)
		begin
			rq_head = rq.pop_front();
			check(cpu_rdata & rq_head[15:8], {8'h00, rq_head[7:0]});
		end
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial
	begin
		d = 8'($urandom(24322));
		rom_data  <= {4'ha, 4'($urandom)};
		boot_data <= {4'hb, 4'($urandom)};
		do_reset(2'b01);
		rd(16'h103d, memmap_pkg::map_reg_reset, 8'hff);
		wr(16'h103d, 8'h23);
		cb = 16'h3000;
		rd(16'h303d, 8'h23, 8'hff);
		wr(16'h303d, 8'h45);
		rd(16'h303d, 8'h23, 8'hff);
		wr(16'h2000, d);
		low_power <= 1'b1;
		idle(4);
		rd(16'h2000, d, 8'hff);
		low_power <= 1'b0;
		rd(16'he000, rom_data, 8'hff);
		rd(16'hbf40, 8'h60, 8'hf0);
		erase_all();
		rd(16'hb600, memmap_pkg::nvm_erased, 8'hff);
		wr(16'h303b, 8'h03);
		rd(16'h303b, 8'h00, 8'hff);
		prog(16'hb600, 8'h55);
		rd(16'hb600, 8'h55, 8'hff);
		prog(16'hb600, 8'h5f);
		rd(16'hb600, 8'h55, 8'hff);
		wr(16'h3039, 8'h40);
		idle(1);
		check(pump_clock_sel, 1'b1);
		wr(16'h303f, 8'h0e);
		rd(16'hb600, 8'h60, 8'hf0);
		wr(16'h303f, 8'h0c);
		rd(16'he000, 8'h60, 8'hf0);
		idle(1);
		do_reset(2'b01);
		wr(16'h0000, ~d);
		idle(70);
		wr(16'h103d, 8'h23);
		rd(16'h103d, 8'h01, 8'hff);
		rd(16'h0000, ~d, 8'hff);
		idle(1);
		do_reset(2'b01);
		wr(16'h103d, 8'hef);
		rd(16'hf03d, 8'hef, 8'hff);
		wr(16'he000, d);
		rd(16'he000, d, 8'hff);
		rd(16'he100, rom_data, 8'hff);
		rd(16'hf035, memmap_pkg::undriven_value, 8'hff);
		rd(16'hf100, rom_data, 8'hff);
		idle(1);
		do_reset(2'b00);
		wr(16'h103f, 8'h0d);
		rd(16'he000, rom_data, 8'hff);
		idle(1);
		do_reset(2'b10);
		rd(16'hbf40, boot_data, 8'hff);
		rd(16'hbfc0, boot_data, 8'hff);
		rd(16'hc000, 8'h60, 8'hf0);
		idle(1);
		do_reset(2'b11);
		rd(16'hbfc0, 8'h60, 8'hf0);
		rd(16'he000, rom_data, 8'hff);
		idle(3);
		stop_test();
	end

endmodule : tb_top
